// ### rtl/acs_chain_ctrl.sv
// acs_chain_ctrl: serial output, daisy chain, start-up, bypass and pin test.
// Assumes clock is the converter clock; every pin input is asynchronous.
`timescale 1ns/1ps
`include "acs_regs.svh"

module acs_chain_ctrl
   import acs_pkg::*;
#(
   parameter int unsigned STARTUP_CYCLES = `ACS_STARTUP_CYCLES,
   parameter logic [2:0] BYPASS_FORMAT = `ACS_FMT_BYPASS
)
(
   // converter clock and reset
   input wire logic clock,
   input wire logic reset,
   // per-supply reset detector outputs, high when supply is good
   input wire logic [2:0] supply_ok,
   // static selection pins
   input wire logic [7:0] channel_powerdown,
   input wire logic operating_mode_bit0,
   input wire logic operating_mode_bit1,
   input wire logic interface_format_bit0,
   input wire logic interface_format_bit1,
   input wire logic interface_format_bit2,
   input wire logic [1:0] test_select,
   // divider select pin
   input wire logic clock_divide_select_in,
   output logic clock_divide_select_out,
   output logic clock_divide_select_oe,
   // shift clock pin
   input wire logic shift_clock_in,
   output logic shift_clock_out,
   output logic shift_clock_oe,
   // data-ready or frame strobe pin
   input wire logic ready_or_frame_pin_in,
   output logic ready_or_frame_pin_out,
   output logic ready_or_frame_pin_oe,
   // chain serial input pin
   input wire logic chain_in,
   output logic chain_out,
   output logic chain_oe,
   // alignment pin
   input wire logic align_in,
   output logic align_out,
   output logic align_oe,
   // serial outputs, bit 0 is the primary output
   output logic [7:0] serial_out,
   // conversion words from the decimation filter, channel 1 first
   input wire logic conv_valid,
   output logic conv_ready,
   input wire logic [23:0] conv_word,
   input wire logic conv_last,
   // raw modulator bits
   input wire logic [7:0] mod_bits,
   // status
   output logic filter_enable,
   output logic startup_done,
   output logic align_pulse
);

   localparam int CW = `ACS_FIFO_CNT_W;
   localparam logic [`ACS_STARTUP_W-1:0] START_LAST = `ACS_STARTUP_W'(STARTUP_CYCLES - 1);

   acs_pins_t pins_raw;
   acs_pins_t pins_s1_q;
   acs_pins_t cfg;
   logic shift_prev_q;
   logic frame_prev_q;
   logic align_prev_q;
   logic sclk_fall;
   logic frame_rise;
   logic test_mode;
   logic bypass;
   logic fmt_spi;
   logic fmt_frame;
   logic all_off;
   logic iface_on;
   logic por;
   acs_phase_t phase_q;
   logic [`ACS_STARTUP_W-1:0] start_cnt_q;
   logic [`ACS_WITHHELD_W-1:0] withheld_q;
   acs_shift_t state_q;
   logic [23:0] word_q;
   logic [4:0] bit_q;
   logic [2:0] chan_q;
   logic serial_bit_q;
   logic data_ready_n_q;
   logic load_now;
   logic next_chan;
   logic pop;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [23:0] fifo_out_data;
   logic [CW-1:0] fifo_count;
   logic [`ACS_DIV_W-1:0] div_q;
   logic [`ACS_DIV_W-1:0] div_n;
   logic mod_clk_q;
   logic [7:0] mod_data_q;

   // zero the word of a powered-down channel, keeping its slot
   function automatic logic [23:0] mask_word(input logic [23:0] w, input logic pd);
      mask_word = pd ? 24'h000000 : w;
   endfunction

   function automatic logic [`ACS_DIV_W-1:0] div_ratio(input logic [1:0] m, input logic cd);
      case (m)
         `ACS_MODE_HS: div_ratio = `ACS_DIV_4;
         `ACS_MODE_HR: div_ratio = `ACS_DIV_4;
         `ACS_MODE_LP: div_ratio = cd ? `ACS_DIV_8 : `ACS_DIV_4;
         `ACS_MODE_LS: div_ratio = cd ? `ACS_DIV_40 : `ACS_DIV_8;
         default: div_ratio = `ACS_DIV_4;
      endcase
   endfunction

   assign pins_raw = '{powerdown: channel_powerdown,
                       mode: {operating_mode_bit1, operating_mode_bit0},
                       format: {interface_format_bit2, interface_format_bit1,
                                interface_format_bit0},
                       clock_divide_select: clock_divide_select_in, test: test_select,
                       shift_clk: shift_clock_in, frame: ready_or_frame_pin_in,
                       chain: chain_in, align: align_in, supply_ok: supply_ok};

   // two-flop synchroniser; only cfg feeds logic
   always_ff @(posedge clock)
   begin
      pins_s1_q <= pins_raw;
      cfg <= pins_s1_q;
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         shift_prev_q <= 1'b0;
         frame_prev_q <= 1'b0;
         align_prev_q <= 1'b0;
         align_pulse <= 1'b0;
      end
      else
      begin
         shift_prev_q <= cfg.shift_clk;
         frame_prev_q <= cfg.frame;
         align_prev_q <= cfg.align;
         align_pulse <= cfg.align && !align_prev_q && !test_mode;
      end
   end

   assign sclk_fall = shift_prev_q && !cfg.shift_clk;
   assign frame_rise = !frame_prev_q && cfg.frame;
   assign test_mode = cfg.test == `ACS_TEST_PIN;
   assign bypass = !test_mode && cfg.format == BYPASS_FORMAT;
   assign fmt_spi = cfg.format == `ACS_FMT_SPI_A || cfg.format == `ACS_FMT_SPI_B;
   assign fmt_frame = cfg.format == `ACS_FMT_FS_A || cfg.format == `ACS_FMT_FS_B;
   assign all_off = &cfg.powerdown;
   assign iface_on = !test_mode && !bypass && !all_off && (fmt_spi || fmt_frame);
   assign por = reset || !(&cfg.supply_ok);

   // start-up count, then withheld conversions
   always_ff @(posedge clock)
   begin
      if (por)
      begin
         phase_q <= ACS_PH_COUNT;
         start_cnt_q <= '0;
         withheld_q <= '0;
      end
      else
      begin
         case (phase_q)
            ACS_PH_COUNT:
            begin
               if (start_cnt_q == START_LAST)
               begin
                  phase_q <= ACS_PH_WITHHOLD;
               end
               else
               begin
                  start_cnt_q <= `ACS_STARTUP_W'(start_cnt_q + 1'b1);
               end
            end
            ACS_PH_WITHHOLD:
            begin
               if (conv_valid && conv_last)
               begin
                  withheld_q <= `ACS_WITHHELD_W'(withheld_q + 1'b1);
                  if (withheld_q == `ACS_WITHHELD_W'(`ACS_WITHHELD - 1'b1))
                  begin
                     phase_q <= ACS_PH_RUN;
                  end
               end
            end
            ACS_PH_RUN:
            begin
               phase_q <= ACS_PH_RUN;
            end
            default:
            begin
               phase_q <= ACS_PH_COUNT;
            end
         endcase
      end
   end

   // withheld words are taken and dropped
   assign conv_ready = (phase_q == ACS_PH_WITHHOLD) ||
                       (phase_q == ACS_PH_RUN && !bypass && fifo_in_ready);
   assign fifo_in_valid = conv_valid && phase_q == ACS_PH_RUN && !bypass;
   assign filter_enable = !bypass && phase_q != ACS_PH_COUNT;
   assign startup_done = phase_q == ACS_PH_RUN;

   acs_fifo #(
      .WIDTH(`ACS_WORD_BITS),
      .DEPTH(`ACS_FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .reset(reset),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(conv_word),
      .out_valid(fifo_out_valid),
      .out_ready(pop),
      .out_data(fifo_out_data),
      .count(fifo_count)
   );

   // frame starts on data-ready in SPI style, on strobe edge otherwise
   assign load_now = iface_on && phase_q == ACS_PH_RUN && fifo_count >= `ACS_FRAME_WORDS &&
                     (fmt_spi ? state_q != ACS_SH_WORDS : frame_rise);
   assign next_chan = state_q == ACS_SH_WORDS && sclk_fall && bit_q == `ACS_LAST_BIT &&
                      chan_q != `ACS_LAST_CHAN;
   assign pop = fifo_out_valid && (load_now || next_chan);

   always_ff @(posedge clock)
   begin
      if (por || !iface_on || phase_q != ACS_PH_RUN)
      begin
         state_q <= ACS_SH_IDLE;
         word_q <= '0;
         bit_q <= '0;
         chan_q <= '0;
         serial_bit_q <= 1'b0;
      end
      else if (load_now)
      begin
         state_q <= ACS_SH_WORDS;
         word_q <= mask_word(fifo_out_data, cfg.powerdown[0]);
         serial_bit_q <= fifo_out_data[23] && !cfg.powerdown[0];
         bit_q <= '0;
         chan_q <= '0;
      end
      else if (sclk_fall)
      begin
         case (state_q)
            ACS_SH_WORDS:
            begin
               if (bit_q != `ACS_LAST_BIT)
               begin
                  bit_q <= 5'(bit_q + 1'b1);
                  serial_bit_q <= word_q[22];
                  word_q <= {word_q[22:0], 1'b0};
               end
               else if (chan_q != `ACS_LAST_CHAN)
               begin
                  bit_q <= '0;
                  chan_q <= 3'(chan_q + 1'b1);
                  word_q <= mask_word(fifo_out_data, cfg.powerdown[3'(chan_q + 1'b1)]);
                  serial_bit_q <= fifo_out_data[23] &&
                                  !cfg.powerdown[3'(chan_q + 1'b1)];
               end
               else
               begin
                  state_q <= ACS_SH_CHAIN;
                  serial_bit_q <= cfg.chain;
               end
            end
            ACS_SH_CHAIN:
            begin
               serial_bit_q <= cfg.chain;
            end
            ACS_SH_IDLE:
            begin
               serial_bit_q <= 1'b0;
            end
            default:
            begin
               state_q <= ACS_SH_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (por || !iface_on || phase_q != ACS_PH_RUN)
      begin
         data_ready_n_q <= 1'b1;
      end
      else if (load_now && fmt_spi)
      begin
         data_ready_n_q <= 1'b0;
      end
      else if (sclk_fall)
      begin
         data_ready_n_q <= 1'b1;
      end
   end

   // modulator clock divider for bypass
   assign div_n = div_ratio(cfg.mode, cfg.clock_divide_select);

   always_ff @(posedge clock)
   begin
      if (reset || !bypass)
      begin
         div_q <= '0;
         mod_clk_q <= 1'b0;
         mod_data_q <= '0;
      end
      else
      begin
         div_q <= (div_q >= `ACS_DIV_W'(div_n - 1'b1)) ? '0 : `ACS_DIV_W'(div_q + 1'b1);
         mod_clk_q <= div_q < (div_n >> 1);
         if (div_q == (div_n >> 1))
         begin
            mod_data_q <= mod_bits;
         end
      end
   end

   // pin drivers
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         serial_out <= '0;
         chain_out <= 1'b0;
         chain_oe <= 1'b0;
         align_out <= 1'b0;
         align_oe <= 1'b0;
         clock_divide_select_out <= 1'b0;
         clock_divide_select_oe <= 1'b0;
         ready_or_frame_pin_out <= 1'b1;
         ready_or_frame_pin_oe <= 1'b0;
         shift_clock_out <= 1'b0;
         shift_clock_oe <= 1'b0;
      end
      else if (test_mode)
      begin
         serial_out <= cfg.powerdown;
         chain_out <= cfg.mode[0];
         chain_oe <= 1'b1;
         align_out <= cfg.mode[1];
         align_oe <= 1'b1;
         clock_divide_select_out <= cfg.format[0];
         clock_divide_select_oe <= 1'b1;
         ready_or_frame_pin_out <= cfg.format[1];
         ready_or_frame_pin_oe <= 1'b1;
         shift_clock_out <= cfg.format[2];
         shift_clock_oe <= 1'b1;
      end
      else
      begin
         serial_out <= bypass ? mod_data_q : {7'h00, serial_bit_q};
         chain_out <= 1'b0;
         chain_oe <= 1'b0;
         align_out <= 1'b0;
         align_oe <= 1'b0;
         clock_divide_select_out <= 1'b0;
         clock_divide_select_oe <= 1'b0;
         ready_or_frame_pin_out <= bypass ? 1'b0 : data_ready_n_q;
         ready_or_frame_pin_oe <= bypass || fmt_spi;
         shift_clock_out <= bypass && mod_clk_q;
         shift_clock_oe <= bypass;
      end
   end

   a_por_restart: assert property (@(posedge clock) por |=>
      phase_q == ACS_PH_COUNT && start_cnt_q == '0 && withheld_q == '0)
      else $error("start-up counters not restarted");

   a_startup_count: assert property (@(posedge clock) disable iff (reset)
      (!por && $past(!por) && phase_q == ACS_PH_WITHHOLD && $past(phase_q) == ACS_PH_COUNT)
      |-> $past(start_cnt_q) == START_LAST)
      else $error("conversion began before start-up count ended");

   a_withhold_end: assert property (@(posedge clock) disable iff (reset)
      (!por && phase_q == ACS_PH_WITHHOLD && conv_valid && conv_last &&
       withheld_q != `ACS_WITHHELD_W'(`ACS_WITHHELD - 1'b1)) |=> !startup_done)
      else $error("withheld conversions ended early");

   a_withheld_ready: assert property (@(posedge clock) disable iff (reset)
      (phase_q != ACS_PH_RUN && fmt_spi && iface_on) |=> ##1
      (ready_or_frame_pin_out || $past(test_mode) || $past(bypass)))
      else $error("data-ready low while conversions withheld");

   a_ready_release: assert property (@(posedge clock) disable iff (reset)
      (!data_ready_n_q && sclk_fall && !load_now) |=> data_ready_n_q)
      else $error("data-ready not released on shift clock fall");

   a_chain_pass: assert property (@(posedge clock) disable iff (reset)
      (!por && iface_on && phase_q == ACS_PH_RUN && state_q == ACS_SH_CHAIN &&
       sclk_fall && !load_now) |=> serial_bit_q == $past(cfg.chain))
      else $error("chain input not passed through");

   a_frame_load: assert property (@(posedge clock) disable iff (reset)
      (!por && fmt_frame && iface_on && phase_q == ACS_PH_RUN && frame_rise &&
       fifo_count >= `ACS_FRAME_WORDS) |=> state_q == ACS_SH_WORDS && bit_q == '0)
      else $error("frame strobe did not load data");

   a_all_off: assert property (@(posedge clock) disable iff (reset)
      (all_off && !test_mode) |=> ##1 serial_out[0] == 1'b0)
      else $error("serial output active with all channels off");

   a_pin_map: assert property (@(posedge clock) disable iff (reset)
      test_mode |=> serial_out == $past(cfg.powerdown) && shift_clock_oe &&
      shift_clock_out == $past(cfg.format[2]) && chain_out == $past(cfg.mode[0]))
      else $error("pin test routing wrong");

   a_mod_divide: assert property (@(posedge clock) disable iff (reset)
      (bypass && $stable(div_n) && div_q == `ACS_DIV_W'(div_n - 1'b1)) |=>
      (div_q == '0 || !bypass))
      else $error("modulator clock ratio wrong");

endmodule // acs_chain_ctrl

// ### rtl/acs_fifo.sv
// acs_fifo: conversion word buffer with registered head word.
// Assumes one clock; source and sink use valid/ready handshakes.
`timescale 1ns/1ps
`include "acs_regs.svh"

module acs_fifo
   import acs_pkg::*;
#(
   parameter int WIDTH = `ACS_WORD_BITS,
   parameter int DEPTH = `ACS_FIFO_DEPTH
)
(
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   // occupancy including head word
   output logic [$clog2(DEPTH+1)-1:0] count
);

   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [CW-1:0] mem_cnt_q;
   logic head_valid_q;
   logic [WIDTH-1:0] head_q;
   logic push;
   logic refill;

   assign count = CW'(mem_cnt_q + CW'(head_valid_q));
   assign in_ready = count < CW'(DEPTH);
   assign push = in_valid && in_ready;
   assign refill = (mem_cnt_q != '0) && (!head_valid_q || out_ready);
   assign out_valid = head_valid_q;
   assign out_data = head_q;

   always_ff @(posedge clock)
   begin
      if (push)
      begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         mem_cnt_q <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_q <= AW'(wr_ptr_q + 1'b1);
         end
         if (refill)
         begin
            rd_ptr_q <= AW'(rd_ptr_q + 1'b1);
         end
         mem_cnt_q <= CW'(mem_cnt_q + CW'(push) - CW'(refill));
      end
   end

   // head register: read data always leave a flip-flop
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         head_valid_q <= 1'b0;
         head_q <= '0;
      end
      else if (refill)
      begin
         head_valid_q <= 1'b1;
         head_q <= mem_q[rd_ptr_q];
      end
      else if (out_ready)
      begin
         head_valid_q <= 1'b0;
      end
   end

endmodule // acs_fifo

// ### rtl/acs_pkg.sv
// acs_pkg: types shared by the output-side control block.
// Assumes acs_regs.svh supplies the figures.
`include "acs_regs.svh"

package acs_pkg;

   // start-up phases, gray along power-on path
   typedef enum logic [1:0] {
      ACS_PH_COUNT = 2'h0,
      ACS_PH_WITHHOLD = 2'h1,
      ACS_PH_RUN = 2'h3
   } acs_phase_t;

   // serial shift engine states
   typedef enum logic [1:0] {
      ACS_SH_IDLE = 2'h0,
      ACS_SH_WORDS = 2'h1,
      ACS_SH_CHAIN = 2'h3
   } acs_shift_t;

   // every pin input sampled together through the synchroniser
   typedef struct packed {
      logic [7:0] powerdown;
      logic [1:0] mode;
      logic [2:0] format;
      logic clock_divide_select;
      logic [1:0] test;
      logic shift_clk;
      logic frame;
      logic chain;
      logic align;
      logic [2:0] supply_ok;
   } acs_pins_t;

endpackage

// ### rtl/acs_regs.svh
// acs_regs.svh: named constants for the converter output-side control block.
// Assumes inclusion by bare name from any file that needs the figures.
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

// channel and word geometry
`define ACS_CHANNELS 8
`define ACS_WORD_BITS 24
`define ACS_LAST_BIT 5'h17
`define ACS_LAST_CHAN 3'h7
`define ACS_FRAME_WORDS 5'h08
`define ACS_FIFO_DEPTH 16
`define ACS_FIFO_CNT_W 5

// start-up sequencing: 2^18 clock cycles, then 129 withheld conversions
`define ACS_STARTUP_CYCLES 262144
`define ACS_STARTUP_W 19
`define ACS_WITHHELD 8'h81
`define ACS_WITHHELD_W 8

// test-select codes
`define ACS_TEST_PIN 2'h3

// interface format codes
`define ACS_FMT_SPI_A 3'h0
`define ACS_FMT_SPI_B 3'h1
`define ACS_FMT_FS_A 3'h3
`define ACS_FMT_FS_B 3'h4
`define ACS_FMT_BYPASS 3'h7

// operating modes and modulator clock ratios
`define ACS_MODE_HS 2'h0
`define ACS_MODE_HR 2'h1
`define ACS_MODE_LP 2'h2
`define ACS_MODE_LS 2'h3
`define ACS_DIV_W 6
`define ACS_DIV_4 6'h04
`define ACS_DIV_8 6'h08
`define ACS_DIV_40 6'h28

`endif

// ### verification/acs_host_model.sv
// acs_host_model: host reading the primary serial output, shift clock at clock/16.
// Assumes run rises only once data-ready is low, and falls before the next frame.
`timescale 1ns/1ps
module acs_host_model
(
   // clock
   input wire logic clock,
   // control and serial data
   input wire logic run,
   input wire logic primary_serial_out, // one stream of 8 channels
   // pins driven toward the converter
   output logic shift_clock,
   output logic chain_bit,
   // received bits
   output logic [23:0] got,
   output int n_bits
);
   int phase = 0;
   initial
   begin
      shift_clock = 1'b0;
      chain_bit = 1'b0;
      got = 24'h000000;
      n_bits = 0;
   end
   // stop-clock shifting, low while idle
   always @(posedge clock)
   begin
      if (!run)
      begin
         phase <= 0;
         shift_clock <= 1'b0;
         n_bits <= 0;
      end
      else
      begin
         phase <= (phase + 1) % 16;
         if (phase == 7)
         begin
            shift_clock <= 1'b1;
            got <= {got[22:0], primary_serial_out};
            n_bits <= n_bits + 1;
         end
         if (phase == 15)
            shift_clock <= 1'b0;
      end
      chain_bit <= run;
   end
endmodule // acs_host_model

// ### verification/tb_adc_chain_startup_bypass_test.sv
// tb_adc_chain_startup_bypass_test: start-up, readout, bypass and pin test.
// Assumes acs_chain_ctrl with a start-up count of 16 and bypass format 7.
`timescale 1ns/1ps
module tb_adc_chain_startup_bypass_test;
   logic clock = 1'b0, reset = 1'b1, run = 1'b0, cv = 1'b0, cl = 1'b0, div = 1'b1;
   logic [2:0] sup = 3'h0, fmt = 3'h0;
   logic [1:0] md = 2'h0, tst = 2'h0;
   logic [7:0] pd = 8'h00, mb = 8'h3C, so;
   logic [23:0] cw = 24'h000000, got;
   logic cdo, cdoe, sco, scoe, rfo, rfoe, cho, choe, alo, aloe, crdy, fen, sdone, hsck, hch;
   logic fs = 1'b0, al = 1'b0, apl;
   int n_bits, n_mismatch = 0, n_tests = 0, k;
   logic [2:0] sel [6] = '{3'h1, 3'h3, 3'h5, 3'h4, 3'h7, 3'h6};
   int nd [6] = '{4, 4, 8, 4, 40, 8};
   // pin levels from all drivers
   wire sck = scoe ? sco : hsck;
   wire chn = choe ? cho : hch;
   wire cdi = cdoe ? cdo : div;
   wire rfi = rfoe ? rfo : fs;
   wire ali = aloe ? alo : al;
   always #4 clock = ~clock;
   acs_chain_ctrl #(.STARTUP_CYCLES(16)) uut (.clock(clock), .reset(reset), .supply_ok(sup),
      .channel_powerdown(pd), .operating_mode_bit0(md[0]), .operating_mode_bit1(md[1]),
      .interface_format_bit0(fmt[0]), .interface_format_bit1(fmt[1]),
      .interface_format_bit2(fmt[2]), .test_select(tst), .clock_divide_select_in(cdi),
      .clock_divide_select_out(cdo), .clock_divide_select_oe(cdoe), .shift_clock_in(sck),
      .shift_clock_out(sco), .shift_clock_oe(scoe), .ready_or_frame_pin_in(rfi),
      .ready_or_frame_pin_out(rfo), .ready_or_frame_pin_oe(rfoe), .chain_in(chn),
      .chain_out(cho), .chain_oe(choe), .align_in(ali), .align_out(alo), .align_oe(aloe),
      .serial_out(so), .conv_valid(cv), .conv_ready(crdy), .conv_word(cw), .conv_last(cl),
      .mod_bits(mb), .filter_enable(fen), .startup_done(sdone), .align_pulse(apl));
   acs_host_model host (.clock(clock), .run(run), .primary_serial_out(so[0]),
      .shift_clock(hsck), .chain_bit(hch), .got(got), .n_bits(n_bits));
   task cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task chk(input logic [23:0] a, input logic [23:0] e, input string m);
      n_tests++;
      if (a !== e)
      begin
         n_mismatch++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask
   task finish_test;
      $display("mismatches %0d, comparisons %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task send_frame(input logic [23:0] b);
      for (int c = 0; c < 8; c++)
      begin
         cv = 1'b1;
         cw = b + 24'(c);
         cl = (c == 7);
         while (crdy !== 1'b1) cyc(1);
         cyc(1);
      end
      cv = 1'b0;
      cl = 1'b0;
   endtask
   task t_startup;
      sup = 3'h7;
      cyc(6);
      chk(crdy, 0, "words taken during count");
      chk(sdone, 0, "done during count");
      cyc(30);
      chk(crdy, 1, "words refused after count");
      for (int f = 0; f < 129; f++)
         send_frame(24'h000000);
      chk(rfo, 1, "data-ready low while withheld");
      cyc(4);
      chk(sdone, 1, "not running after 129 conversions");
      $display("test startup done");
   endtask
   task t_readout;
      al = 1'b1;
      cyc(3);
      chk(apl, 1, "alignment pulse missing");
      cyc(1);
      chk(apl, 0, "alignment pulse too long");
      al = 1'b0;
      pd = 8'h04;
      cyc(4);
      send_frame(24'hA5C300);
      for (int i = 0; i < 40 && rfo !== 1'b0; i++)
         cyc(1);
      chk(rfo, 0, "data-ready not low");
      run = 1'b1;
      for (int c = 0; c < 8; c++)
      begin
         while (n_bits < 24 * (c + 1)) cyc(1);
         chk(got, (c == 2) ? 24'h000000 : 24'hA5C300 + 24'(c), "channel word");
         chk(rfo, 1, "data-ready not back high");
      end
      while (n_bits < 216) cyc(1);
      chk(got, 24'hFFFFFF, "chain bits");
      run = 1'b0;
      pd = 8'hFF;
      cyc(4);
      send_frame(24'h123456);
      cyc(40);
      chk(rfo, 1, "data-ready with all channels down");
      chk(so, 0, "output with all channels down");
      $display("test readout done");
   endtask
   task t_frame;
      pd = 8'h00;
      fmt = 3'h3;
      cyc(6);
      chk(so, 0, "output before frame strobe");
      fs = 1'b1;
      cyc(6);
      run = 1'b1;
      while (n_bits < 24) cyc(1);
      chk(got, 24'h123456, "first word after frame strobe");
      run = 1'b0;
      fs = 1'b0;
      $display("test frame done");
   endtask
   task t_bypass;
      pd = 8'h00;
      fmt = 3'h7;
      for (int i = 0; i < 6; i++)
      begin
         {md, div} = sel[i];
         cyc(12);
         while (sco === 1'b1) cyc(1);
         while (sco === 1'b0) cyc(1);
         k = 0;
         while (sco === 1'b1) begin cyc(1); k++; end
         while (sco === 1'b0) begin cyc(1); k++; end
         chk(k[23:0], nd[i][23:0], "modulator clock period");
      end
      chk(scoe, 1, "shift clock not driven");
      chk(fen, 0, "filter still on");
      chk(so, mb, "modulator bits");
      $display("test bypass done");
   endtask
   task t_pintest;
      fmt = 3'h5;
      md = 2'h2;
      pd = 8'hA6;
      tst = 2'h3;
      cyc(6);
      chk(so, pd, "powerdown to outputs");
      chk({cho, alo, cdo, rfo, sco}, {md[0], md[1], fmt[0], fmt[1], fmt[2]}, "pin map");
      chk({choe, aloe, cdoe, rfoe, scoe}, 5'h1F, "enables in pin test");
      tst = 2'h0;
      cyc(6);
      chk({choe, aloe, cdoe, rfoe, scoe}, 5'h00, "enables after pin test");
      $display("test pin map done");
   endtask
   initial
   begin
      cyc(12);
      chk({rfo, rfoe, so}, 10'h200, "reset pin levels");
      reset = 1'b0;
      t_startup;
      sup = 3'h6;
      cyc(4);
      chk(sdone, 0, "supply drop kept running");
      t_startup;
      t_readout;
      t_frame;
      t_bypass;
      t_pintest;
      finish_test;
   end
   initial
   begin
      repeat (30000) @(posedge clock);
      n_mismatch++;
      $display("unexpected at %0t: watchdog expired", $time);
      finish_test;
   end
endmodule // tb_adc_chain_startup_bypass_test
